// ==== rtl/cps_pkg.sv ====
package touch_pkg;

    // Register byte offsets
    localparam logic [7:0] MAIN_OFFSET    = 8'h00;
    localparam logic [7:0] CHANNEL_OFFSET = 8'h04;
    localparam logic [7:0] COUNT_OFFSET   = 8'h08;
    localparam int         DECODE_W       = 8;

    // Field positions in sense_control_main
    localparam int ENABLE_BIT    = 7;
    localparam int RANGE_BIT     = 6;
    localparam int CURRENT_MSB   = 3;
    localparam int CURRENT_LSB   = 2;
    localparam int DIRECTION_BIT = 1;
    localparam int TIMER_SEL_BIT = 0;

    // Field positions in sense_channel_select
    localparam int CHANNEL_MSB = 3;
    localparam int CHANNEL_LSB = 0;

    // Writable masks and reset values
    localparam logic [7:0] MAIN_WRITE_MASK    = 8'hCD;
    localparam logic [7:0] CHANNEL_WRITE_MASK = 8'h0F;
    localparam logic [7:0] MAIN_RESET         = 8'h00;
    localparam logic [7:0] CHANNEL_RESET      = 8'h00;

    // Encodings
    localparam logic [1:0] CURRENT_OFF     = 2'h0;
    localparam logic [1:0] CURRENT_LOW     = 2'h1;
    localparam logic [1:0] CURRENT_MEDIUM  = 2'h2;
    localparam logic [1:0] CURRENT_HIGH    = 2'h3;
    localparam logic [1:0] SECOND_SRC_OSC  = 2'h3;
    localparam int         NUM_CHANNELS    = 12;
    localparam int         CHANNEL_W       = 4;
    localparam int         COUNT_W         = 16;
    localparam int         INSTR_DIVIDE    = 4;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_NOISE,
        MODE_LOW,
        MODE_MEDIUM,
        MODE_HIGH
    } osc_mode_type;

endpackage : touch_pkg

// ==== rtl/cps_reg_if.sv ====
`timescale 1ns/1ps
interface touch_reg_if;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport bus (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : touch_reg_if

// ==== rtl/cps_ahb_slave.sv ====
`timescale 1ns/1ps
module touch_ahb_slave
    import touch_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    touch_reg_if.bus         regs
);

    // One wait state: register access happens in the first data-phase cycle,
    // so a read right after a write always sees the written value.
    logic        pend_q, pend_d;
    logic        write_q, write_d;
    logic [7:0]  addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;

    always_comb begin
        pend_d  = 1'b0;
        write_d = write_q;
        addr_d  = addr_q;
        rdata_d = rdata_q;
        ready_d = 1'b1;
        if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            pend_d  = 1'b1;
            write_d = hwrite;
            addr_d  = haddr[DECODE_W-1:0];
            ready_d = 1'b0;
        end
        if (pend_q && !write_q) begin
            rdata_d = regs.rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q  <= 1'b0;
            write_q <= 1'b0;
            addr_q  <= 8'h00;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b1;
        end else begin
            pend_q  <= pend_d;
            write_q <= write_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
        end
    end

    assign regs.wr_en = pend_q && write_q;
    assign regs.rd_en = pend_q && !write_q;
    assign regs.addr  = addr_q;
    assign regs.wdata = hwdata;
    assign hrdata     = rdata_q;
    assign hreadyout  = ready_q;
    assign hresp      = HRESP_OKAY;

endmodule : touch_ahb_slave

// ==== rtl/cps_osc_route.sv ====
`timescale 1ns/1ps
module touch_osc_route
    import touch_pkg::*;
#(
    parameter int DIVIDE = INSTR_DIVIDE
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic osc_raw,
    input  wire logic osc_gate,
    output logic      osc_level,
    output logic      osc_rise,
    output logic      instr_tick
);

    if (DIVIDE < 2) begin : g_divide_check
        $error("DIVIDE must be at least 2");
    end

    logic                      level_q, level_d;
    logic                      rise_q, rise_d;
    logic [$clog2(DIVIDE)-1:0] div_q, div_d;
    logic                      tick_q, tick_d;

    always_comb begin
        // Gated level holds low so the timers see no spurious edges
        level_d = osc_gate & osc_raw;
        rise_d  = level_d & ~level_q;
        tick_d  = (div_q == '0);
        if (div_q == $clog2(DIVIDE)'(DIVIDE - 1)) begin
            div_d = '0;
        end else begin
            div_d = div_q + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            div_q   <= '0;
            tick_q  <= 1'b0;
        end else begin
            level_q <= level_d;
            rise_q  <= rise_d;
            div_q   <= div_d;
            tick_q  <= tick_d;
        end
    end

    assign osc_level  = level_q;
    assign osc_rise   = rise_q;
    assign instr_tick = tick_q;

endmodule : touch_osc_route

// ==== rtl/cps_top.sv ====
// Function
// - With the module enabled, except low range code 00, the oscillator runs and can clock a timer during sleep.
// - The first timer receives no counts while the core sleeps.
// - Main bit 7 enables the sensing module when 1, disables when 0.
// - Main bit 6 selects high range (external references) or low range (internal).
// - Unimplemented bits of both registers ignore writes and read zero.
// - Low range: current code 00 turns oscillator off; 01-11 low, medium, high.
// - High range: code 00 is noise detection, oscillator on, no charge current.
// - Read-only main bit 1 shows oscillator sourcing (1) or sinking (0).
// - External clock mode set: main bit 0 picks oscillator (1) or clock pin (0).
// - External clock mode clear: first timer counts system clock divided by four.
// - Module disabled: channel field has no effect, no channel connected.
// - Module enabled: codes 0 to 11 connect channel 0 to 11.
// - All implemented fields reset to zero on every reset.
// - Second timer source code 11 clocks that timer from the oscillator.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module touch_top
    import touch_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  sleep_active,
    input  wire logic                  timer_external_clock_mode,
    input  wire logic                  timer_external_clock_pin,
    input  wire logic [1:0]            second_timer_clock_source,
    input  wire logic                  oscillator_in,
    output logic                       oscillator_power,
    output logic                       charge_current_enable,
    output logic                       reference_range_out,
    output logic      [1:0]            current_range_out,
    output logic      [CHANNELS-1:0]   channel_connect,
    output logic                       first_timer_tick,
    output logic                       second_timer_tick
);

    if (CHANNELS < 1 || CHANNELS > (1 << CHANNEL_W)) begin : g_channels_check
        $error("CHANNELS out of range");
    end

    touch_reg_if reg_bus ();

    touch_ahb_slave touch_ahb_slave_inst (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .regs      (reg_bus.bus)
    );

    // hsize is unused: only whole-word transfers reach this block

    // Channel decode, used only for the connect vector
    function automatic logic [CHANNELS-1:0] decode_channel(input logic enable, input logic [CHANNEL_W-1:0] code);
        logic [CHANNELS-1:0] onehot;
        onehot = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            if (enable && code == CHANNEL_W'(i)) begin
                onehot[i] = 1'b1;
            end
        end
        return onehot;
    endfunction : decode_channel

    // Register state
    logic [7:0]         main_q, main_d;
    logic [7:0]         chan_q, chan_d;
    logic [COUNT_W-1:0] count_q, count_d;

    // Osc route outputs
    logic osc_level;
    logic osc_rise;
    logic instr_tick;

    // Mode and outputs
    osc_mode_type        mode_q, mode_d;
    logic                power_q, power_d;
    logic                charge_q, charge_d;
    logic                range_q, range_d;
    logic [1:0]          current_q, current_d;
    logic [CHANNELS-1:0] connect_q, connect_d;
    logic                pin_prev_q, pin_prev_d;
    logic                tick1_q, tick1_d;
    logic                tick2_q, tick2_d;

    logic enabled;
    logic osc_running;
    logic pin_rise;

    assign enabled = main_q[ENABLE_BIT];

    touch_osc_route #(
        .DIVIDE (INSTR_DIVIDE)
    ) touch_osc_route_inst (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .osc_raw    (oscillator_in),
        .osc_gate   (osc_running),
        .osc_level  (osc_level),
        .osc_rise   (osc_rise),
        .instr_tick (instr_tick)
    );

    // Register writes; sleep does not touch the fields, so the oscillator keeps running
    always_comb begin
        main_d  = main_q;
        chan_d  = chan_q;
        count_d = count_q;
        if (reg_bus.wr_en && reg_bus.addr == MAIN_OFFSET) begin
            main_d = reg_bus.wdata[7:0] & MAIN_WRITE_MASK;
        end
        if (reg_bus.wr_en && reg_bus.addr == CHANNEL_OFFSET) begin
            chan_d = reg_bus.wdata[7:0] & CHANNEL_WRITE_MASK;
        end
        // Count of oscillator cycles; a write clears it, an edge in that cycle still counts
        if (reg_bus.wr_en && reg_bus.addr == COUNT_OFFSET) begin
            count_d = '0;
        end
        if (osc_rise) begin
            count_d = ((reg_bus.wr_en && reg_bus.addr == COUNT_OFFSET) ? '0 : count_q) + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_q  <= MAIN_RESET;
            chan_q  <= CHANNEL_RESET;
            count_q <= '0;
        end else begin
            main_q  <= main_d;
            chan_q  <= chan_d;
            count_q <= count_d;
        end
    end

    // Read mux: direction bit is live state, reserved bits read zero
    always_comb begin
        reg_bus.rdata = 32'h00000000;
        if (reg_bus.addr == MAIN_OFFSET) begin
            reg_bus.rdata[7:0]           = main_q;
            reg_bus.rdata[DIRECTION_BIT] = osc_level;
        end else if (reg_bus.addr == CHANNEL_OFFSET) begin
            reg_bus.rdata[7:0] = chan_q;
        end else if (reg_bus.addr == COUNT_OFFSET) begin
            reg_bus.rdata[COUNT_W-1:0] = count_q;
        end
    end

    // Power mode decode
    always_comb begin
        mode_d = MODE_OFF;
        if (enabled) begin
            case (main_q[CURRENT_MSB:CURRENT_LSB])
                CURRENT_OFF:    mode_d = main_q[RANGE_BIT] ? MODE_NOISE : MODE_OFF;
                CURRENT_LOW:    mode_d = MODE_LOW;
                CURRENT_MEDIUM: mode_d = MODE_MEDIUM;
                CURRENT_HIGH:   mode_d = MODE_HIGH;
                default:        mode_d = MODE_OFF;
            endcase
        end
    end

    assign osc_running = (mode_q != MODE_OFF);

    always_comb begin
        power_d   = 1'b0;
        charge_d  = 1'b0;
        range_d   = main_q[RANGE_BIT];
        current_d = main_q[CURRENT_MSB:CURRENT_LSB];
        // Follow the next mode so power and charge change together with the range fields
        case (mode_d)
            MODE_OFF: begin
                power_d  = 1'b0;
                charge_d = 1'b0;
            end
            MODE_NOISE: begin
                power_d  = 1'b1;
                charge_d = 1'b0;
            end
            MODE_LOW, MODE_MEDIUM, MODE_HIGH: begin
                power_d  = 1'b1;
                charge_d = 1'b1;
            end
            default: begin
                power_d  = 1'b0;
                charge_d = 1'b0;
            end
        endcase
        // Reserved codes decode to no channel rather than an alias
        connect_d = decode_channel(enabled, chan_q[CHANNEL_MSB:CHANNEL_LSB]);
    end

    // Timer routing
    assign pin_rise = timer_external_clock_pin & ~pin_prev_q;

    always_comb begin
        pin_prev_d = timer_external_clock_pin;
        if (timer_external_clock_mode) begin
            tick1_d = main_q[TIMER_SEL_BIT] ? osc_rise : pin_rise;
        end else begin
            tick1_d = instr_tick;
        end
        if (sleep_active) begin
            tick1_d = 1'b0;
        end
        // Not gated by sleep: counts go on while the core sleeps
        tick2_d = (second_timer_clock_source == SECOND_SRC_OSC) && osc_rise;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q     <= MODE_OFF;
            power_q    <= 1'b0;
            charge_q   <= 1'b0;
            range_q    <= 1'b0;
            current_q  <= CURRENT_OFF;
            connect_q  <= '0;
            pin_prev_q <= 1'b0;
            tick1_q    <= 1'b0;
            tick2_q    <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            power_q    <= power_d;
            charge_q   <= charge_d;
            range_q    <= range_d;
            current_q  <= current_d;
            connect_q  <= connect_d;
            pin_prev_q <= pin_prev_d;
            tick1_q    <= tick1_d;
            tick2_q    <= tick2_d;
        end
    end

    assign oscillator_power      = power_q;
    assign charge_current_enable = charge_q;
    assign reference_range_out   = range_q;
    assign current_range_out     = current_q;
    assign channel_connect       = connect_q;
    assign first_timer_tick      = tick1_q;
    assign second_timer_tick     = tick2_q;

endmodule : touch_top

// ==== tb/cps_assertions.sv ====
`timescale 1ns/1ps
module touch_assertions
    import touch_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                sleep_active,
    input wire logic                timer_external_clock_mode,
    input wire logic [1:0]          second_timer_clock_source,
    input wire logic                oscillator_in,
    input wire logic                oscillator_power,
    input wire logic                charge_current_enable,
    input wire logic                reference_range_out,
    input wire logic [1:0]          current_range_out,
    input wire logic [CHANNELS-1:0] channel_connect,
    input wire logic                first_timer_tick,
    input wire logic                second_timer_tick
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence taken_s;
        hsel && hready && htrans == HTRANS_NONSEQ && hreadyout;
    endsequence
    sequence instr_run_s;
        (!timer_external_clock_mode && !sleep_active)[*6] ##0 first_timer_tick;
    endsequence
    AST_READY_PULSE: assert property (taken_s |=> !hreadyout ##1 hreadyout)
        else $error("ready not low for exactly one cycle");
    AST_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    AST_ONE_CHANNEL: assert property ($onehot0(channel_connect))
        else $error("more than one channel connected");
    AST_LOW_OFF: assert property (!reference_range_out && current_range_out == CURRENT_OFF |-> !oscillator_power)
        else $error("oscillator on in low range code zero");
    AST_NO_CHARGE: assert property (current_range_out == CURRENT_OFF |-> !charge_current_enable)
        else $error("charge current in off or noise mode");
    AST_CHARGE_ON: assert property (oscillator_power && current_range_out != CURRENT_OFF |-> charge_current_enable)
        else $error("no charge current in active mode");
    AST_SLEEP_FIRST: assert property (sleep_active && $past(sleep_active) |-> !first_timer_tick)
        else $error("first timer ticked in sleep");
    AST_INSTR: assert property (instr_run_s |=> (!first_timer_tick)[*3] ##1 first_timer_tick)
        else $error("instruction tick not every four cycles");
    AST_OSC_TICK: assert property (second_timer_clock_source == SECOND_SRC_OSC && oscillator_power
        && $past(oscillator_power) && $rose(oscillator_in) |-> ##[1:2] second_timer_tick)
        else $error("oscillator edge not passed to second timer");
    AST_STATIC: assert property ((!oscillator_power)[*3] |-> !second_timer_tick)
        else $error("second timer tick with oscillator off");
endmodule : touch_assertions

bind touch_top touch_assertions #(.CHANNELS(CHANNELS)) touch_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_active(sleep_active),
    .timer_external_clock_mode(timer_external_clock_mode),
    .second_timer_clock_source(second_timer_clock_source), .oscillator_in(oscillator_in),
    .oscillator_power(oscillator_power), .charge_current_enable(charge_current_enable),
    .reference_range_out(reference_range_out), .current_range_out(current_range_out),
    .channel_connect(channel_connect), .first_timer_tick(first_timer_tick),
    .second_timer_tick(second_timer_tick)
);

// ==== tb/cps_osc_model.sv ====
`timescale 1ns/1ps
module touch_osc_model #(
    parameter int HALF = 3
) (
    input  wire logic hclk,
    input  wire logic oscillator_power,
    input  wire logic first_timer_tick,
    input  wire logic second_timer_tick,
    output logic      oscillator_in,
    output int        first_count,
    output int        second_count,
    output int        rise_count
);
    int   phase;
    logic prev_in;
    initial begin
        oscillator_in = 1'b0;
        prev_in = 1'b0;
        phase = 0;
        first_count = 0;
        second_count = 0;
        rise_count = 0;
    end
    // Held low while unpowered, so a stale level never fakes an edge
    always @(posedge hclk) begin
        if (oscillator_power && phase == HALF - 1) begin
            oscillator_in <= !oscillator_in;
        end
        // A rise counts only while powered, since the block gates the level in that cycle
        rise_count <= rise_count + int'(oscillator_in && !prev_in && oscillator_power);
        prev_in <= oscillator_in;
        if (!oscillator_power) begin
            oscillator_in <= 1'b0;
        end
        phase <= (oscillator_power && phase < HALF - 1) ? phase + 1 : 0;
        first_count <= first_count + int'(first_timer_tick);
        second_count <= second_count + int'(second_timer_tick);
    end
endmodule : touch_osc_model

// ==== tb/capacitive_touch_sense_control_tb.sv ====
`timescale 1ns/1ps
module capacitive_touch_sense_control_tb;
    import touch_pkg::*;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, sleep_active;
    logic [1:0]  htrans, second_timer_clock_source, current_range_out;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic        timer_external_clock_mode, timer_external_clock_pin, oscillator_in, oscillator_power;
    logic        charge_current_enable, reference_range_out, first_timer_tick, second_timer_tick;
    logic [11:0] channel_connect;
    int          first_count, second_count, rise_count, n_errors, compares, f0, s0, r0, rc;

    touch_top touch_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sleep_active(sleep_active), .timer_external_clock_mode(timer_external_clock_mode),
        .timer_external_clock_pin(timer_external_clock_pin), .oscillator_in(oscillator_in),
        .second_timer_clock_source(second_timer_clock_source), .oscillator_power(oscillator_power),
        .charge_current_enable(charge_current_enable), .reference_range_out(reference_range_out),
        .current_range_out(current_range_out), .channel_connect(channel_connect),
        .first_timer_tick(first_timer_tick), .second_timer_tick(second_timer_tick)
    );
    touch_osc_model #(.HALF(3)) touch_osc_model_inst (
        .hclk(hclk), .oscillator_power(oscillator_power), .first_timer_tick(first_timer_tick),
        .second_timer_tick(second_timer_tick), .oscillator_in(oscillator_in), .first_count(first_count),
        .second_count(second_count), .rise_count(rise_count)
    );

    initial hclk = 1'b0;
    always #20 hclk = ~hclk;

    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // Waits on ready rather than counting cycles, so a slower slave still passes
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n = 0;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        rd = hrdata;
        if (n >= 50) begin
            n_errors++;
            $display("[FAIL] %0t bus ready never came", $time);
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        idle(3);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask : rdc

    task automatic snap;
        f0 = first_count;
        s0 = second_count;
        r0 = rise_count;
    endtask : snap

    initial begin
        hresetn = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
        sleep_active = 1'b0; timer_external_clock_mode = 1'b1; timer_external_clock_pin = 1'b0;
        second_timer_clock_source = 2'h0; n_errors = 0; compares = 0;
        idle(4);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({19'h0, channel_connect, oscillator_power}, 32'h0);
        rdc(MAIN_OFFSET, 32'h0);
        rdc(CHANNEL_OFFSET, 32'h0);
        wr(MAIN_OFFSET, 32'h3F);
        rdc(MAIN_OFFSET, 32'h0D);
        wr(CHANNEL_OFFSET, 32'hFB);
        rdc(CHANNEL_OFFSET, 32'h0B);
        wr(8'h0C, 32'hFF);
        rdc(8'h0C, 32'h0);
        rdc(MAIN_OFFSET, 32'h0D);
        for (int m = 0; m < 8; m++) begin
            wr(MAIN_OFFSET, {24'h0, 1'b1, m[2], 2'b00, m[1:0], 2'b00});
            check({28'h0, oscillator_power, charge_current_enable, current_range_out},
                  {28'h0, m != 0, m[1:0] != 2'h0, m[1:0]});
            check({31'h0, reference_range_out}, {31'h0, m[2]});
        end
        wr(MAIN_OFFSET, 32'h4C);
        check({19'h0, channel_connect, oscillator_power}, 32'h0);
        wr(MAIN_OFFSET, 32'h8C);
        // Reserved channel codes are never written
        for (int c = 0; c < 12; c++) begin
            wr(CHANNEL_OFFSET, c);
            check({20'h0, channel_connect}, 32'h1 << c);
        end
        // Oscillator off before the counting runs, so no edge is in flight at a snapshot
        wr(MAIN_OFFSET, 32'h0);
        wr(COUNT_OFFSET, 32'h0);
        rc = rise_count;
        second_timer_clock_source <= SECOND_SRC_OSC;
        for (int s = 1; s >= 0; s--) begin
            sleep_active <= s[0];
            snap();
            wr(MAIN_OFFSET, 32'hCD);
            idle(60);
            wr(MAIN_OFFSET, 32'h0);
            idle(3);
            check(first_count - f0, (s == 1) ? 0 : rise_count - r0);
            check(second_count - s0, rise_count - r0);
        end
        rdc(COUNT_OFFSET, rise_count - rc);
        snap();
        repeat (5) begin
            timer_external_clock_pin <= 1'b1;
            idle(2);
            timer_external_clock_pin <= 1'b0;
            idle(2);
        end
        idle(4);
        check(first_count - f0, 5);
        timer_external_clock_mode <= 1'b0;
        idle(8);
        snap();
        idle(40);
        check(first_count - f0, 10);
        report_and_stop();
    end

    initial begin
        idle(20000);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : capacitive_touch_sense_control_tb
